/* File: test_xirq_top.sv */
// Self-checking testbench of the extra interrupt and nibble port block.
`timescale 1ns/1ns
module test_xirq_top;
    import xirq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
    logic bit_set = 1'b0, bit_clr = 1'b0, bit_rd = 1'b0;
    logic [5:0] core_req = 6'h00, core_hi = 6'h00;
    logic int_ack = 1'b0, int_reti = 1'b0;
    logic [3:0] ext_low = 4'h0;
    logic [7:0] sfr_rdata, int_vector, rd;
    logic sfr_rvalid, bit_rdata, bit_rvalid, int_req, int_high;
    logic [3:0] nib_pin_in, nib_pin_out, nib_pin_oe;
    xirq_src_t int_src;
    int fail_count = 0;
    int checks_done = 0;

    always #50 ref_clk = ~ref_clk;

    xirq_pin_model PINS (.nib_pin_oe, .ext_low, .pin(nib_pin_in));
    xirq_top DUT (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
        .sfr_rmw, .sfr_rdata, .sfr_rvalid, .bit_addr, .bit_set, .bit_clr,
        .bit_rd, .bit_rdata, .bit_rvalid, .nib_pin_in, .nib_pin_out,
        .nib_pin_oe, .core_req, .core_hi, .int_ack, .int_reti, .int_req,
        .int_vector, .int_src, .int_high);

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    // An unanswered read leaves unknown data so that no compare can pass.
    task automatic rdb(input logic [7:0] a);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        rd = (sfr_rvalid === 1'b1) ? sfr_rdata : 8'hxx;
    endtask
    task automatic rbit(input logic [7:0] a);
        @(negedge ref_clk);
        bit_addr = a;
        bit_rd = 1'b1;
        @(negedge ref_clk);
        bit_rd = 1'b0;
        rd = (bit_rvalid === 1'b1) ? {7'h00, bit_rdata} : 8'hxx;
    endtask
    task automatic bop(input logic [7:0] a, input logic s);
        @(negedge ref_clk);
        bit_addr = a;
        bit_set = s;
        bit_clr = ~s;
        @(negedge ref_clk);
        bit_set = 1'b0;
        bit_clr = 1'b0;
    endtask
    task automatic pulse(input logic ack);
        @(negedge ref_clk);
        int_ack = ack;
        int_reti = ~ack;
        @(negedge ref_clk);
        int_ack = 1'b0;
        int_reti = 1'b0;
    endtask
    task automatic want(input logic [7:0] vec, input logic hi);
        int i;
        for (i = 0; i < 8 && int_req !== 1'b1; i++) @(negedge ref_clk);
        chk("int_req", 8'h01, {7'h00, int_req});
        chk("int_vector", vec, int_vector);
        chk("int_high", {7'h00, hi}, {7'h00, int_high});
        chk("int_src", (vec - 8'h03) >> 3, {5'h00, int_src});
    endtask
    task automatic no_req(input string what);
        chk(what, 8'h00, {7'h00, int_req});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdb(8'hc0);
        chk("ctrl reset", 8'h00, rd);
        rdb(8'hd8);
        chk("port reset", 8'h0f, rd);
        rdb(8'hc1);
        chk("unmapped rvalid", 8'h00, {7'h00, sfr_rvalid});
        $display("t_reset done");
    endtask
    task automatic t_port;
        wr(8'hd8, 8'hfa);
        cyc(3);
        rdb(8'hd8);
        chk("port pins", 8'h0a, rd);
        ext_low = 4'h2;
        cyc(3);
        rdb(8'hd8);
        chk("pulled pin", 8'h08, rd);
        sfr_rmw = 1'b1;
        rdb(8'hd8);
        chk("port latch", 8'h0a, rd);
        sfr_rmw = 1'b0;
        ext_low = 4'h0;
        wr(8'hd8, 8'h0f);
        cyc(3);
        $display("t_port done");
    endtask
    task automatic t_bits;
        int i;
        logic [7:0] e;
        e = 8'h00;
        for (i = 0; i < 8; i++) begin
            if (i != 1 && i != 5) begin
                bop(8'hc0 + i[7:0], 1'b1);
                e[i] = 1'b1;
                rdb(8'hc0);
                chk("bit set", e, rd);
            end
        end
        bop(8'hc2, 1'b0);
        rdb(8'hc0);
        chk("bit clear", 8'hd9, rd);
        rbit(8'hc7);
        chk("bit read set", 8'h01, rd);
        rbit(8'hc2);
        chk("bit read clear", 8'h00, rd);
        bop(8'hd8, 1'b0);
        cyc(3);
        rbit(8'hd8);
        chk("port bit pin", 8'h00, rd);
        rdb(8'hd8);
        chk("port bit clear", 8'h0e, rd);
        bop(8'hd8, 1'b1);
        cyc(3);
        wr(8'hc0, 8'h00);
        $display("t_bits done");
    endtask
    task automatic t_edge3;
        wr(8'hc0, 8'h10);
        ext_low = 4'h8;
        cyc(6);
        no_req("masked irq3");
        rdb(8'hc0);
        chk("irq3 flag", 8'h30, rd);
        ext_low = 4'h0;
        bop(8'hc6, 1'b1);
        want(8'h3b, 1'b0);
        pulse(1'b1);
        rdb(8'hc0);
        chk("flag cleared", 8'h50, rd);
        pulse(1'b0);
        cyc(2);
        no_req("edge not repeated");
        wr(8'hc0, 8'h00);
        $display("t_edge3 done");
    endtask
    task automatic t_level2;
        wr(8'hc0, 8'h04);
        ext_low = 4'h4;
        want(8'h33, 1'b0);
        pulse(1'b1);
        cyc(2);
        no_req("equal level waits");
        pulse(1'b0);
        want(8'h33, 1'b0);
        ext_low = 4'h0;
        cyc(5);
        no_req("level released");
        wr(8'hc0, 8'h00);
        $display("t_level2 done");
    endtask
    task automatic t_prio;
        wr(8'hc0, 8'hd5);
        core_req = 6'h01;
        ext_low = 4'h4;
        cyc(5);
        want(8'h03, 1'b0);
        pulse(1'b1);
        core_req = 6'h00;
        ext_low = 4'h0;
        cyc(2);
        no_req("low pending waits");
        ext_low = 4'h8;
        want(8'h3b, 1'b1);
        pulse(1'b1);
        ext_low = 4'h0;
        cyc(2);
        no_req("nested holds all");
        pulse(1'b0);
        pulse(1'b0);
        want(8'h33, 1'b0);
        pulse(1'b1);
        rdb(8'hc0);
        chk("irq2 flag cleared", 8'hd5, rd);
        pulse(1'b0);
        wr(8'hc0, 8'h00);
        $display("t_prio done");
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        cyc(3);
        t_reset;
        t_port;
        t_bits;
        t_edge3;
        t_level2;
        t_prio;
        stop_test;
    end
    initial begin
        #500000;
        fail_count++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test;
    end
endmodule // test_xirq_top

/* File: xirq_arb_if.sv */
// Interface between the service control and the vector arbiter.
`timescale 1ns/1ns
interface xirq_arb_if;
    logic [7:0] req;
    logic [7:0] hi;
    logic allow_low;
    logic allow_high;
    logic valid;
    logic high;
    xirq_pkg::xirq_src_t src;
    logic [7:0] vector;
    modport arb (input req, hi, allow_low, allow_high,
                 output valid, high, src, vector);
    modport ctl (output req, hi, allow_low, allow_high,
                 input valid, high, src, vector);
endinterface

/* File: xirq_checker.sv */
// Port assertions of the extra interrupt and nibble port block.
`timescale 1ns/1ns
module xirq_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic [3:0] nib_pin_out,
    input wire logic [3:0] nib_pin_oe,
    input wire logic int_ack,
    input wire logic int_reti,
    input wire logic int_req,
    input wire logic [7:0] int_vector,
    input wire xirq_pkg::xirq_src_t int_src,
    input wire logic int_high
);
    import xirq_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Sequences and assertions
    // ----------------------------------------------------------------
    sequence s_mapped_rd;
        sfr_rd && (sfr_addr == 8'hc0 || sfr_addr == 8'hd8);
    endsequence
    sequence s_ack_low;
        int_ack && int_req && !int_high && !int_reti;
    endsequence
    a_rd_answer: assert property (s_mapped_rd |=> sfr_rvalid)
        else $error("mapped read not answered");
    a_rvalid_cause: assert property (
        sfr_rvalid |-> $past(sfr_rd)
        && ($past(sfr_addr) == 8'hc0 || $past(sfr_addr) == 8'hd8))
        else $error("read answer without mapped read");
    a_idle_rdata: assert property (
        !sfr_rvalid |-> sfr_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_upper_zero: assert property (
        sfr_rvalid && $past(sfr_addr) == 8'hd8 |-> sfr_rdata[7:4] == 4'h0)
        else $error("port upper nibble not zero");
    a_port_write: assert property (
        sfr_wr && sfr_addr == 8'hd8 |=> nib_pin_out == $past(sfr_wdata[3:0]))
        else $error("port latch missed write");
    a_drive_low: assert property (
        sfr_wr && sfr_addr == 8'hd8 |=> nib_pin_oe == ~$past(sfr_wdata[3:0]))
        else $error("pin drive not inverse of written data");
    a_vector_map: assert property (
        int_req |-> int_vector == 8'h03 + {2'b00, int_src, 3'b000})
        else $error("vector does not match source");
    a_low_waits: assert property (
        s_ack_low |=> !int_req || int_high)
        else $error("low request shown in low service");
    a_high_alone: assert property (
        int_ack && int_req && int_high && !int_reti |=> !int_req)
        else $error("request shown in high service");
endmodule // xirq_checker

bind xirq_top xirq_checker u_chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_rvalid, .nib_pin_out, .nib_pin_oe,
    .int_ack, .int_reti, .int_req, .int_vector, .int_src, .int_high);

/* File: xirq_params.svh */
// Constants of the extra external interrupt and nibble port block.
`ifndef XIRQ_PARAMS_SVH
`define XIRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Special-function addresses and reset values
// ----------------------------------------------------------------------
`define XIRQ_ADDR_CTRL 8'hc0
`define XIRQ_ADDR_PORT 8'hd8
`define XIRQ_CTRL_RST 8'h00
`define XIRQ_PORT_RST 4'hf
`define XIRQ_SYNC_RST 1'b1

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define XIRQ_B_IT2 0
`define XIRQ_B_IE2 1
`define XIRQ_B_EX2 2
`define XIRQ_B_PX2 3
`define XIRQ_B_IT3 4
`define XIRQ_B_IE3 5
`define XIRQ_B_EX3 6
`define XIRQ_B_PX3 7

// ----------------------------------------------------------------------
// Pins, sources and vectors
// ----------------------------------------------------------------------
`define XIRQ_PIN_IRQ2 2
`define XIRQ_PIN_IRQ3 3
`define XIRQ_SRC_IRQ2 3'h6
`define XIRQ_SRC_IRQ3 3'h7
`define XIRQ_VEC_BASE 8'h03
`define XIRQ_VEC_SHIFT 3

`endif

/* File: xirq_pin_model.sv */
// Model of the external circuitry on the nibble port pins.
`timescale 1ns/1ns
module xirq_pin_model (
    input wire logic [3:0] nib_pin_oe,
    input wire logic [3:0] ext_low,
    output logic [3:0] pin
);
    // A pin reads high through its pull-up unless a side pulls it low.
    assign pin = ~(nib_pin_oe | ext_low);
endmodule // xirq_pin_model

/* File: xirq_pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ns
`include "xirq_params.svh"
module xirq_pin_sync #(
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= {W{`XIRQ_SYNC_RST}};
            q <= {W{`XIRQ_SYNC_RST}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // xirq_pin_sync

/* File: xirq_pkg.sv */
// Types shared by the extra external interrupt block.
package xirq_pkg;
    typedef logic [2:0] xirq_src_t;
    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_LOW,
        SVC_HIGH,
        SVC_NEST
    } xirq_svc_t;
endpackage

/* File: xirq_top.sv */
// Extra external interrupts, vector arbiter and nibble I/O port.
`timescale 1ns/1ns
`include "xirq_params.svh"
module xirq_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic [7:0] bit_addr,
    input wire logic bit_set,
    input wire logic bit_clr,
    input wire logic bit_rd,
    output logic bit_rdata,
    output logic bit_rvalid,
    input wire logic [3:0] nib_pin_in,
    output logic [3:0] nib_pin_out,
    output logic [3:0] nib_pin_oe,
    input wire logic [5:0] core_req,
    input wire logic [5:0] core_hi,
    input wire logic int_ack,
    input wire logic int_reti,
    output logic int_req,
    output logic [7:0] int_vector,
    output xirq_pkg::xirq_src_t int_src,
    output logic int_high
);
    import xirq_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Byte write or single-bit write to the register at base.
    // Returns the hit flag above the new register value.
    function automatic logic [8:0] sfr_write(
        input logic [7:0] base,
        input logic [7:0] cur,
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] wdata,
        input logic bset,
        input logic bclr,
        input logic [7:0] baddr
    );
        logic hit;
        logic [7:0] val;
        hit = 1'b0;
        val = cur;
        if (wr && addr == base) begin
            hit = 1'b1;
            val = wdata;
        end else if ((bset || bclr) && baddr[7:3] == base[7:3]) begin
            hit = 1'b1;
            val[baddr[2:0]] = bset;
        end
        return {hit, val};
    endfunction

    // Next value of a request flag in either trigger mode.
    // In edge mode a detected edge wins over any clear in the same cycle.
    function automatic logic flag_next(
        input logic edge_mode,
        input logic cur,
        input logic fall,
        input logic pin_low,
        input logic hw_clr,
        input logic sw_we,
        input logic sw_val
    );
        logic nxt;
        nxt = cur;
        if (!edge_mode) begin
            nxt = pin_low;
        end else begin
            if (sw_we) begin
                nxt = sw_val;
            end
            if (hw_clr) begin
                nxt = 1'b0;
            end
            if (fall) begin
                nxt = 1'b1;
            end
        end
        return nxt;
    endfunction

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [8:0] ctrl_wr;
    logic [3:0] latch_q;
    logic [8:0] port_wr;
    logic [3:0] pin_s;
    logic [3:0] pin_prev_q;
    logic fall2;
    logic fall3;
    logic clr2;
    logic clr3;
    logic flag2_d;
    logic flag3_d;
    logic irq2_req;
    logic irq3_req;
    logic [7:0] ctrl_view;
    logic [7:0] port_view;
    xirq_svc_t svc_q;
    xirq_svc_t svc_d;
    logic ack_ok;

    // A bit address selects its register by its upper five bits.
    localparam logic [4:0] ctrl_bit_base = 5'(`XIRQ_ADDR_CTRL >> 3);
    localparam logic [4:0] port_bit_base = 5'(`XIRQ_ADDR_PORT >> 3);

    xirq_arb_if arb_bus ();

    // ------------------------------------------------------------------
    // Pin synchroniser and edge detection
    // ------------------------------------------------------------------
    xirq_pin_sync #(
        .W(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d(nib_pin_in),
        .q(pin_s)
    );

    // The edge register resets high, the idle level of a pulled-up pin,
    // so leaving reset never shows a false falling edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_prev_q <= {4{`XIRQ_SYNC_RST}};
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    // The interrupt inputs are active low, taken from port pins 3 and 2.
    assign fall2 = pin_prev_q[`XIRQ_PIN_IRQ2]
                   && !pin_s[`XIRQ_PIN_IRQ2];
    assign fall3 = pin_prev_q[`XIRQ_PIN_IRQ3]
                   && !pin_s[`XIRQ_PIN_IRQ3];

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    assign ctrl_wr = sfr_write(`XIRQ_ADDR_CTRL, ctrl_q, sfr_wr, sfr_addr,
                               sfr_wdata, bit_set, bit_clr,
                               bit_addr);

    // An ack clears only the flag of the source shown with it.
    assign ack_ok = int_ack && arb_bus.valid;
    assign clr2 = ack_ok && arb_bus.src == `XIRQ_SRC_IRQ2;
    assign clr3 = ack_ok && arb_bus.src == `XIRQ_SRC_IRQ3;

    // Level mode copies the inverted pin, so the request lasts as long
    // as the source holds the pin low.
    assign flag2_d = flag_next(ctrl_q[`XIRQ_B_IT2], ctrl_q[`XIRQ_B_IE2],
                               fall2, !pin_s[`XIRQ_PIN_IRQ2], clr2,
                               ctrl_wr[8],
                               ctrl_wr[`XIRQ_B_IE2]);
    assign flag3_d = flag_next(ctrl_q[`XIRQ_B_IT3], ctrl_q[`XIRQ_B_IE3],
                               fall3, !pin_s[`XIRQ_PIN_IRQ3], clr3,
                               ctrl_wr[8],
                               ctrl_wr[`XIRQ_B_IE3]);

    always_comb begin
        ctrl_d = ctrl_wr[7:0];
        ctrl_d[`XIRQ_B_IE2] = flag2_d;
        ctrl_d[`XIRQ_B_IE3] = flag3_d;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= `XIRQ_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl_view = ctrl_q;

    // ------------------------------------------------------------------
    // Nibble port latch and pins
    // ------------------------------------------------------------------
    // Bit operations on port bits 7 to 4 hit the register but change nothing.
    assign port_wr = sfr_write(`XIRQ_ADDR_PORT, {4'h0, latch_q}, sfr_wr,
                               sfr_addr, sfr_wdata, bit_set, bit_clr,
                               bit_addr);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_q <= `XIRQ_PORT_RST;
        end else if (port_wr[8]) begin
            latch_q <= port_wr[3:0];
        end
    end

    // A latch bit of 0 drives the pin low; a 1 releases it to the
    // internal pull-up so it can serve as an input or interrupt.
    assign nib_pin_out = latch_q;
    assign nib_pin_oe = ~latch_q;

    // Byte reads return the pins; read-modify-write reads the latch.
    assign port_view = {4'h0,
                        sfr_rmw ? latch_q : pin_s};

    // ------------------------------------------------------------------
    // Requests to the arbiter
    // ------------------------------------------------------------------
    assign irq2_req = ctrl_d[`XIRQ_B_EX2] && flag2_d;
    assign irq3_req = ctrl_d[`XIRQ_B_EX3] && flag3_d;

    // Next-cycle values feed the arbiter so that a cleared flag or new
    // service level is seen in the same edge that the ack is taken.
    assign arb_bus.req = {irq3_req, irq2_req, core_req};
    assign arb_bus.hi = {ctrl_d[`XIRQ_B_PX3],
                         ctrl_d[`XIRQ_B_PX2],
                         core_hi};
    assign arb_bus.allow_high = svc_d == SVC_IDLE
                                || svc_d == SVC_LOW;
    assign arb_bus.allow_low = svc_d == SVC_IDLE;

    xirq_vector_arb u_arb (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(arb_bus)
    );

    assign int_req = arb_bus.valid;
    assign int_vector = arb_bus.vector;
    assign int_src = arb_bus.src;
    assign int_high = arb_bus.high;

    // ------------------------------------------------------------------
    // Service level tracking
    // ------------------------------------------------------------------
    // Only a low routine can be interrupted, and only by a high request,
    // so nesting never goes deeper than two levels.
    always_comb begin
        svc_d = svc_q;
        case (svc_q)
            SVC_IDLE: begin
                if (ack_ok) begin
                    svc_d = arb_bus.high ? SVC_HIGH : SVC_LOW;
                end
            end
            SVC_LOW: begin
                if (ack_ok) begin
                    svc_d = SVC_NEST;
                end else if (int_reti) begin
                    svc_d = SVC_IDLE;
                end
            end
            SVC_HIGH: begin
                if (int_reti) begin
                    svc_d = SVC_IDLE;
                end
            end
            SVC_NEST: begin
                if (int_reti) begin
                    svc_d = SVC_LOW;
                end
            end
            default: begin
                svc_d = SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            svc_q <= SVC_IDLE;
        end else begin
            svc_q <= svc_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Answers stand for one cycle and read as zero at all other times.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            sfr_rvalid <= 1'b0;
        end else begin
            sfr_rvalid <= 1'b0;
            sfr_rdata <= 8'h00;
            if (sfr_rd && sfr_addr == `XIRQ_ADDR_CTRL) begin
                sfr_rdata <= ctrl_view;
                sfr_rvalid <= 1'b1;
            end else if (sfr_rd && sfr_addr == `XIRQ_ADDR_PORT) begin
                sfr_rdata <= port_view;
                sfr_rvalid <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_rdata <= 1'b0;
            bit_rvalid <= 1'b0;
        end else begin
            bit_rvalid <= 1'b0;
            bit_rdata <= 1'b0;
            if (bit_rd && bit_addr[7:3] == ctrl_bit_base) begin
                bit_rdata <= ctrl_view[bit_addr[2:0]];
                bit_rvalid <= 1'b1;
            end else if (bit_rd
                         && bit_addr[7:3] == port_bit_base) begin
                bit_rdata <= port_view[bit_addr[2:0]];
                bit_rvalid <= 1'b1;
            end
        end
    end
endmodule // xirq_top

/* File: xirq_vector_arb.sv */
// Eight-source two-level vector arbiter with registered outputs.
`timescale 1ns/1ns
`include "xirq_params.svh"
module xirq_vector_arb (
    input wire logic ref_clk,
    input wire logic rst_n,
    xirq_arb_if.arb bus
);
    import xirq_pkg::*;

    // Lowest index wins, so source 0 is polled first.
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    logic [3:0] pick_hi;
    logic [3:0] pick_lo;

    assign pick_hi = first_set(bus.req & bus.hi);
    assign pick_lo = first_set(bus.req & ~bus.hi);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus.valid <= 1'b0;
            bus.high <= 1'b0;
            bus.src <= '0;
            bus.vector <= `XIRQ_VEC_BASE;
        end else if (bus.allow_high && pick_hi[3]) begin
            bus.valid <= 1'b1;
            bus.high <= 1'b1;
            bus.src <= pick_hi[2:0];
            bus.vector <= (8'(pick_hi[2:0]) << `XIRQ_VEC_SHIFT)
                          | `XIRQ_VEC_BASE;
        end else if (bus.allow_low && pick_lo[3]) begin
            bus.valid <= 1'b1;
            bus.high <= 1'b0;
            bus.src <= pick_lo[2:0];
            bus.vector <= (8'(pick_lo[2:0]) << `XIRQ_VEC_SHIFT)
                          | `XIRQ_VEC_BASE;
        end else begin
            bus.valid <= 1'b0;
        end
    end
endmodule // xirq_vector_arb
